// >>> verilog/msf_flag_bank.sv
/*
  msf_flag_bank: status and request flags of a motion-control CPU.
  Assumes detectors and amplifier link run on clk; peer reset pins are
  asynchronous and are synchronised here.
*/
// The register addresses and the strobed register port were left to the implementer.
`timescale 1ns/1ns
module msf_flag_bank (
  input  wire logic                 clk,
  input  wire logic                 rst_b,
  input  wire msf_pkg::msf_req_t    reg_req,
  output logic [31:0]               reg_rdata,
  output logic                      irq,
  input  wire logic [5:0]           axis_setting_bad,
  input  wire msf_pkg::msf_detail_t axis_detail,
  input  wire logic                 test_req_fail,
  input  wire msf_pkg::msf_detail_t test_detail,
  input  wire logic                 servo_prog_bad,
  input  wire msf_pkg::msf_detail_t servo_detail,
  output logic                      param_read_start,
  output logic [7:0]                param_read_axis,
  input  wire logic                 param_read_done,
  input  wire logic [3:0]           mcr_start,
  input  wire logic [3:0]           mcr_done_ok,
  input  wire logic [3:0]           cpu_reset_b,
  input  wire logic [3:0]           cpu_present,
  output logic                      peer_down_err,
  output logic [15:0]               peer_down_code
);

  // address match, used by every register decode
  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  logic        axis_err_r;
  logic        test_err_r;
  logic        servo_err_r;
  logic        reading_r;
  logic        peer_down_r;
  logic [3:0]  rd_done_r;
  logic [3:0]  in_reset_r;
  logic [3:0]  in_reset_nxt;
  logic [3:0]  rst_s1_r;
  logic [3:0]  rst_s2_r;
  logic        req_r;
  logic        req_prev_r;
  logic [7:0]  axis_r;
  logic [5:0]  irq_stat_r;
  logic [5:0]  irq_mask_r;
  logic [5:0]  ev;
  logic [15:0] axis_det_r [3];
  logic [15:0] test_det_r [2];
  logic [15:0] servo_det_r [2];
  logic [31:0] flags_w;
  logic [31:0] rdata_nxt;
  logic        wr_flags;
  logic        wr_irq;
  logic        axis_err_nxt;
  logic        req_rise;
  logic        peer_rise;
  msf_pkg::msf_rd_state_t rd_st_r;

  assign wr_flags = reg_req.wr && hit(reg_req.addr, msf_pkg::FLAGS_OFS);
  assign wr_irq   = reg_req.wr && hit(reg_req.addr, msf_pkg::IRQ_STAT_OFS);

  // axis setting error is a pure level of the six checks
  assign axis_err_nxt = |axis_setting_bad;
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      axis_err_r <= 1'b0;
    end else begin
      axis_err_r <= axis_err_nxt;
    end
  end

  // axis detail words latched only on the flag's rising edge
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      for (int i = 0; i < 3; i++) axis_det_r[i] <= 16'h0000;
    end else if (axis_err_nxt && !axis_err_r) begin
      axis_det_r[0] <= axis_detail.w0;
      axis_det_r[1] <= axis_detail.w1;
      axis_det_r[2] <= axis_detail.w2;
    end
  end

  // sticky error flags; a new error beats a clear in the same cycle
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      test_err_r  <= 1'b0;
      servo_err_r <= 1'b0;
    end else begin
      if (test_req_fail) begin
        test_err_r <= 1'b1;
      end else if (wr_flags && reg_req.wdata[msf_pkg::TEST_ERR_BIT]) begin
        test_err_r <= 1'b0;
      end
      if (servo_prog_bad) begin
        servo_err_r <= 1'b1;
      end else if (wr_flags && reg_req.wdata[msf_pkg::SERVO_ERR_BIT]) begin
        servo_err_r <= 1'b0;
      end
    end
  end

  // detail words follow each error report, latest one kept
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      for (int i = 0; i < 2; i++) begin
        test_det_r[i]  <= 16'h0000;
        servo_det_r[i] <= 16'h0000;
      end
    end else begin
      if (test_req_fail) begin
        test_det_r[0] <= test_detail.w0;
        test_det_r[1] <= test_detail.w1;
      end
      if (servo_prog_bad) begin
        servo_det_r[0] <= servo_detail.w0;
        servo_det_r[1] <= servo_detail.w1;
      end
    end
  end

  // control word: request bit and read axis, both software owned
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      req_r      <= 1'b0;
      req_prev_r <= 1'b0;
      axis_r     <= msf_pkg::AXIS_RESET;
    end else begin
      req_prev_r <= req_r;
      if (reg_req.wr && hit(reg_req.addr, msf_pkg::CTRL_OFS)) begin
        req_r  <= reg_req.wdata[msf_pkg::READ_REQ_BIT];
        axis_r <= reg_req.wdata[msf_pkg::READ_AXIS_LSB +: 8];
      end
    end
  end

  // only an off-to-on change counts; holding the bit high does nothing
  assign req_rise = req_r && !req_prev_r;

  // parameter read sequencer; a rise while busy is dropped, not queued
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      rd_st_r         <= msf_pkg::RD_IDLE;
      reading_r       <= 1'b0;
      param_read_axis <= msf_pkg::AXIS_RESET;
    end else begin
      case (rd_st_r)
        msf_pkg::RD_IDLE: begin
          if (req_rise) begin
            rd_st_r         <= msf_pkg::RD_START;
            reading_r       <= 1'b1;
            param_read_axis <= axis_r;
          end
        end
        msf_pkg::RD_START: begin
          rd_st_r <= msf_pkg::RD_WAIT;
        end
        msf_pkg::RD_WAIT: begin
          if (param_read_done) begin
            rd_st_r   <= msf_pkg::RD_IDLE;
            reading_r <= 1'b0;
          end
        end
        default: begin
          rd_st_r   <= msf_pkg::RD_IDLE;
          reading_r <= 1'b0;
        end
      endcase
    end
  end

  assign param_read_start = (rd_st_r == msf_pkg::RD_START);

  // peer reset pins are asynchronous: two flops before any use
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      rst_s1_r <= 4'h0;
      rst_s2_r <= 4'h0;
    end else begin
      rst_s1_r <= ~cpu_reset_b | ~cpu_present;
      rst_s2_r <= rst_s1_r;
    end
  end

  // per-cpu resetting and read-complete flags
  genvar g;
  generate
    for (g = 0; g < msf_pkg::NCPU; g++) begin : g_cpu
      // the first CPU holding reset drags all others with it
      assign in_reset_nxt[g] = rst_s2_r[g] | rst_s2_r[0];
      always_ff @(posedge clk) begin
        if (!rst_b) begin
          rd_done_r[g] <= 1'b0;
        end else if (mcr_done_ok[g]) begin
          rd_done_r[g] <= 1'b1;
        end else if (mcr_start[g]) begin
          rd_done_r[g] <= 1'b0;
        end
      end
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      in_reset_r <= 4'h0;
    end else begin
      in_reset_r <= in_reset_nxt;
    end
  end

  // only CPUs two to four own-reset raise the peer error
  assign peer_rise = |(rst_s2_r[3:1] & ~in_reset_r[3:1]);
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      peer_down_r    <= 1'b0;
      peer_down_code <= 16'h0000;
    end else begin
      if (peer_rise) begin
        peer_down_r    <= 1'b1;
        peer_down_code <= msf_pkg::PEER_DOWN_CODE;
      end else if (wr_flags && reg_req.wdata[msf_pkg::PEER_DOWN_BIT]) begin
        peer_down_r <= 1'b0;
      end
    end
  end
  assign peer_down_err = peer_down_r;

  // interrupt events, each a single-cycle pulse
  assign ev[msf_pkg::EV_AXIS]  = axis_err_nxt && !axis_err_r;
  assign ev[msf_pkg::EV_TEST]  = test_req_fail;
  assign ev[msf_pkg::EV_SERVO] = servo_prog_bad;
  assign ev[msf_pkg::EV_PDONE] = (rd_st_r == msf_pkg::RD_WAIT) && param_read_done;
  assign ev[msf_pkg::EV_MCR]   = |mcr_done_ok;
  assign ev[msf_pkg::EV_PEER]  = peer_rise;

  // sticky status, write one to clear; a set in the same cycle wins
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      irq_stat_r <= 6'h00;
      irq_mask_r <= 6'h00;
    end else begin
      irq_stat_r <= ev | (irq_stat_r & ~(wr_irq ? reg_req.wdata[5:0] : 6'h00));
      if (reg_req.wr && hit(reg_req.addr, msf_pkg::IRQ_MASK_OFS)) begin
        irq_mask_r <= reg_req.wdata[5:0];
      end
    end
  end
  assign irq = |(irq_stat_r & irq_mask_r);

  // flag word as software sees it
  always_comb begin
    flags_w = msf_pkg::RESET_WORD;
    flags_w[msf_pkg::AXIS_ERR_BIT]  = axis_err_r;
    flags_w[msf_pkg::TEST_ERR_BIT]  = test_err_r;
    flags_w[msf_pkg::SERVO_ERR_BIT] = servo_err_r;
    flags_w[msf_pkg::READING_BIT]   = reading_r;
    flags_w[msf_pkg::PEER_DOWN_BIT] = peer_down_r;
    flags_w[msf_pkg::RD_DONE_LSB +: 4]  = rd_done_r;
    flags_w[msf_pkg::IN_RESET_LSB +: 4] = in_reset_r;
  end

  // read mux; unmapped addresses read zero
  always_comb begin
    rdata_nxt = 32'h0000_0000;
    if (hit(reg_req.addr, msf_pkg::FLAGS_OFS)) rdata_nxt = flags_w;
    if (hit(reg_req.addr, msf_pkg::CTRL_OFS)) begin
      rdata_nxt = {16'h0000, axis_r, 7'h00, req_r};
    end
    if (hit(reg_req.addr, msf_pkg::IRQ_STAT_OFS)) rdata_nxt = {26'h0, irq_stat_r};
    if (hit(reg_req.addr, msf_pkg::IRQ_MASK_OFS)) rdata_nxt = {26'h0, irq_mask_r};
    if (hit(reg_req.addr, msf_pkg::AXIS_DET0_OFS)) rdata_nxt = {16'h0, axis_det_r[0]};
    if (hit(reg_req.addr, msf_pkg::AXIS_DET1_OFS)) rdata_nxt = {16'h0, axis_det_r[1]};
    if (hit(reg_req.addr, msf_pkg::AXIS_DET2_OFS)) rdata_nxt = {16'h0, axis_det_r[2]};
    if (hit(reg_req.addr, msf_pkg::TEST_DET0_OFS)) rdata_nxt = {16'h0, test_det_r[0]};
    if (hit(reg_req.addr, msf_pkg::TEST_DET1_OFS)) rdata_nxt = {16'h0, test_det_r[1]};
    if (hit(reg_req.addr, msf_pkg::SERVO_DET0_OFS)) rdata_nxt = {16'h0, servo_det_r[0]};
    if (hit(reg_req.addr, msf_pkg::SERVO_DET1_OFS)) rdata_nxt = {16'h0, servo_det_r[1]};
    if (hit(reg_req.addr, msf_pkg::PEER_CODE_OFS)) rdata_nxt = {16'h0, peer_down_code};
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      reg_rdata <= 32'h0000_0000;
    end else begin
      reg_rdata <= reg_req.rd ? rdata_nxt : 32'h0000_0000;
    end
  end

  // assertions
  sequence s_req_rise;
    req_r && !req_prev_r && rd_st_r == msf_pkg::RD_IDLE;
  endsequence
  sequence s_start_then_wait;
    param_read_start ##1 (rd_st_r == msf_pkg::RD_WAIT);
  endsequence

  property p_axis_level;
    @(posedge clk) disable iff (!rst_b) 1'b1 |=> axis_err_r == $past(|axis_setting_bad);
  endproperty
  a_axis_level: assert property (p_axis_level) else $error("axis flag wrong");

  property p_axis_det;
    @(posedge clk) disable iff (!rst_b)
      (axis_err_nxt && !axis_err_r) |=> axis_det_r[2] == $past(axis_detail.w2);
  endproperty
  a_axis_det: assert property (p_axis_det) else $error("axis detail not latched");

  property p_test_err;
    @(posedge clk) disable iff (!rst_b) test_req_fail |=> test_err_r;
  endproperty
  a_test_err: assert property (p_test_err) else $error("test error not set");

  property p_test_det;
    @(posedge clk) disable iff (!rst_b)
      test_req_fail |=> test_det_r[0] == $past(test_detail.w0)
                        && test_det_r[1] == $past(test_detail.w1);
  endproperty
  a_test_det: assert property (p_test_det) else $error("test detail not latched");

  property p_servo_err;
    @(posedge clk) disable iff (!rst_b)
      servo_prog_bad |=> servo_err_r && servo_det_r[1] == $past(servo_detail.w1);
  endproperty
  a_servo_err: assert property (p_servo_err) else $error("servo error not kept");

  property p_read_start;
    @(posedge clk) disable iff (!rst_b) s_req_rise |=> s_start_then_wait;
  endproperty
  a_read_start: assert property (p_read_start) else $error("read not started");

  property p_reading_hold;
    @(posedge clk) disable iff (!rst_b)
      (rd_st_r != msf_pkg::RD_IDLE) |-> reading_r;
  endproperty
  a_reading_hold: assert property (p_reading_hold) else $error("reading flag dropped");

  property p_reading_end;
    @(posedge clk) disable iff (!rst_b)
      (rd_st_r == msf_pkg::RD_WAIT && param_read_done) |=> !reading_r;
  endproperty
  a_reading_end: assert property (p_reading_end) else $error("reading flag stuck");

  property p_mcr_done;
    @(posedge clk) disable iff (!rst_b) mcr_done_ok[2] |=> rd_done_r[2];
  endproperty
  a_mcr_done: assert property (p_mcr_done) else $error("read complete missing");

  property p_cpu_reset;
    @(posedge clk) disable iff (!rst_b)
      (!cpu_reset_b[3] && cpu_present[3]) [*3] |=> in_reset_r[3];
  endproperty
  a_cpu_reset: assert property (p_cpu_reset) else $error("resetting flag late");

  // checked from the pin, so a broken spread path in the flag logic would show
  property p_cpu1_all;
    @(posedge clk) disable iff (!rst_b)
      (!cpu_reset_b[0] && cpu_present[0]) [*3] |=> &in_reset_r;
  endproperty
  a_cpu1_all: assert property (p_cpu1_all) else $error("cpu1 reset not spread");

  property p_peer_down;
    @(posedge clk) disable iff (!rst_b)
      peer_rise |=> peer_down_err && peer_down_code == msf_pkg::PEER_DOWN_CODE;
  endproperty
  a_peer_down: assert property (p_peer_down) else $error("peer down not raised");

endmodule : msf_flag_bank

// >>> common/msf_pkg.sv
/*
  msf_pkg: constants and carriers for the motion CPU status flag bank.
  Assumes one 20 MHz clock and a plain register port with single-cycle strobes.
*/
package msf_pkg;

  // register offsets, byte addresses of 32-bit words
  localparam logic [7:0] FLAGS_OFS      = 8'h00;
  localparam logic [7:0] CTRL_OFS       = 8'h04;
  localparam logic [7:0] IRQ_STAT_OFS   = 8'h08;
  localparam logic [7:0] IRQ_MASK_OFS   = 8'h0c;
  localparam logic [7:0] AXIS_DET0_OFS  = 8'h10;
  localparam logic [7:0] AXIS_DET1_OFS  = 8'h14;
  localparam logic [7:0] AXIS_DET2_OFS  = 8'h18;
  localparam logic [7:0] TEST_DET0_OFS  = 8'h1c;
  localparam logic [7:0] TEST_DET1_OFS  = 8'h20;
  localparam logic [7:0] SERVO_DET0_OFS = 8'h24;
  localparam logic [7:0] SERVO_DET1_OFS = 8'h28;
  localparam logic [7:0] PEER_CODE_OFS  = 8'h2c;

  // flag word field positions
  localparam int AXIS_ERR_BIT   = 0;
  localparam int TEST_ERR_BIT   = 1;
  localparam int SERVO_ERR_BIT  = 2;
  localparam int READING_BIT    = 4;
  localparam int PEER_DOWN_BIT  = 5;
  localparam int RD_DONE_LSB    = 8;
  localparam int IN_RESET_LSB   = 12;
  // control word field positions
  localparam int READ_REQ_BIT   = 0;
  localparam int READ_AXIS_LSB  = 8;

  // interrupt event bit positions
  localparam int EV_AXIS   = 0;
  localparam int EV_TEST   = 1;
  localparam int EV_SERVO  = 2;
  localparam int EV_PDONE  = 3;
  localparam int EV_MCR    = 4;
  localparam int EV_PEER   = 5;
  localparam int EV_W      = 6;

  localparam int          NCPU          = 4;
  localparam int          NAXIS_SET     = 6;
  localparam logic [15:0] PEER_DOWN_CODE = 16'h1b58;  // decimal 7000
  localparam logic [31:0] RESET_WORD    = 32'h0000_0000;
  localparam logic [7:0]  AXIS_RESET    = 8'h00;

  // register port request
  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } msf_req_t;

  // error detail words delivered beside an error event
  typedef struct packed {
    logic [15:0] w0;
    logic [15:0] w1;
    logic [15:0] w2;
  } msf_detail_t;

  typedef enum logic [2:0] {
    RD_IDLE  = 3'b001,
    RD_START = 3'b010,
    RD_WAIT  = 3'b100
  } msf_rd_state_t;

endpackage : msf_pkg

// >>> tb/msf_amp_model.sv
/*
  msf_amp_model: amplifier side of the parameter read, answers dly+1 cycles after it samples start.
  Assumes start is a one-cycle pulse on clk; done is a one-cycle pulse back.
*/
`timescale 1ns/1ns
module msf_amp_model (
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic       param_read_start,
  input  wire logic [7:0] param_read_axis,
  input  wire logic [7:0] dly,
  output logic            param_read_done,
  output logic [7:0]      axis_seen
);
  logic       busy_r;
  logic [7:0] cnt_r;

  // one transfer at a time; a slow dly keeps the device waiting
  always_ff @(posedge clk) begin
    param_read_done <= 1'b0;
    if (!rst_b) begin
      busy_r    <= 1'b0;
      cnt_r     <= 8'h00;
      axis_seen <= 8'h00;
    end else if (param_read_start) begin
      busy_r    <= 1'b1;
      cnt_r     <= dly;
      axis_seen <= param_read_axis;
    end else if (busy_r) begin
      if (cnt_r == 8'h00) begin
        busy_r          <= 1'b0;
        param_read_done <= 1'b1;
      end else begin
        cnt_r <= cnt_r - 8'h01;
      end
    end
  end
endmodule : msf_amp_model

// >>> tb/tb_msf_flag_bank.sv
/*
  tb_msf_flag_bank: self-checking bench for the status flag bank.
  Assumes the register map of msf_pkg and the amplifier model beside it.
*/
`timescale 1ns/1ns
module tb_msf_flag_bank;
  logic                 clk = 1'b0;
  logic                 rst_b;
  msf_pkg::msf_req_t    reg_req;
  logic [31:0]          reg_rdata;
  logic                 irq;
  logic [5:0]           axis_setting_bad;
  msf_pkg::msf_detail_t axis_detail;
  msf_pkg::msf_detail_t test_detail;
  msf_pkg::msf_detail_t servo_detail;
  logic                 test_req_fail;
  logic                 servo_prog_bad;
  logic                 param_read_start;
  logic [7:0]           param_read_axis;
  logic                 param_read_done;
  logic [3:0]           mcr_start;
  logic [3:0]           mcr_done_ok;
  logic [3:0]           cpu_reset_b;
  logic [3:0]           cpu_present;
  logic                 peer_down_err;
  logic [15:0]          peer_down_code;
  logic [7:0]           dly;
  logic [7:0]           axis_seen;
  logic [7:0]           ax;
  logic [31:0]          rd_val;
  logic [31:0]          e;
  msf_pkg::msf_detail_t d;
  int                   error_cnt = 0;
  int                   samples_checked = 0;
  int                   seed = 29758;

  always #25 clk = ~clk;

  msf_flag_bank uut (.clk(clk), .rst_b(rst_b), .reg_req(reg_req), .reg_rdata(reg_rdata),
    .irq(irq), .axis_setting_bad(axis_setting_bad), .axis_detail(axis_detail),
    .test_req_fail(test_req_fail), .test_detail(test_detail),
    .servo_prog_bad(servo_prog_bad), .servo_detail(servo_detail),
    .param_read_start(param_read_start), .param_read_axis(param_read_axis),
    .param_read_done(param_read_done), .mcr_start(mcr_start), .mcr_done_ok(mcr_done_ok),
    .cpu_reset_b(cpu_reset_b), .cpu_present(cpu_present), .peer_down_err(peer_down_err),
    .peer_down_code(peer_down_code));

  msf_amp_model amp (.clk(clk), .rst_b(rst_b), .param_read_start(param_read_start),
    .param_read_axis(param_read_axis), .dly(dly), .param_read_done(param_read_done),
    .axis_seen(axis_seen));

  task automatic end_sim;
    $display("checked %0d, errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : end_sim

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  function automatic logic [31:0] fb(input int b);
    return 32'h1 << b;
  endfunction : fb

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc

  // one-cycle strobes, changed just after the edge
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    reg_req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    reg_req.wr <= 1'b0;
  endtask : wr

  // read data stands only in the cycle after the strobe
  task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
    @(posedge clk);
    reg_req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    reg_req.rd <= 1'b0;
    #1 rd_val = reg_rdata;
    chk(rd_val & m, exp);
  endtask : rchk

  // bounded wait on start (0) or done (1)
  task automatic wait_sig(input int w);
    int i;
    for (i = 0; i < 200; i++) begin
      @(posedge clk);
      #1 if ((w == 0 ? param_read_start : param_read_done) === 1'b1) break;
    end
    if (i == 200) begin
      error_cnt++;
      $display("BAD t=%0t wait ran out", $time);
      end_sim();
    end
  endtask : wait_sig

  // test (k=0) or servo (k=1) error; detail changes after the pulse
  task automatic err_case(input int k);
    logic [31:0] b;
    b = fb(k ? msf_pkg::SERVO_ERR_BIT : msf_pkg::TEST_ERR_BIT);
    d = {16'($random(seed)), 16'($random(seed)), 16'($random(seed))};
    @(posedge clk);
    if (k == 0) {test_detail, test_req_fail} <= {d, 1'b1};
    else {servo_detail, servo_prog_bad} <= {d, 1'b1};
    @(posedge clk);
    {test_req_fail, servo_prog_bad} <= 2'b00;
    test_detail <= ~d;
    servo_detail <= ~d;
    cyc(2);
    rchk(msf_pkg::FLAGS_OFS, b, b);
    rchk(k ? msf_pkg::SERVO_DET0_OFS : msf_pkg::TEST_DET0_OFS, '1, {16'h0, d.w0});
    rchk(k ? msf_pkg::SERVO_DET1_OFS : msf_pkg::TEST_DET1_OFS, '1, {16'h0, d.w1});
    wr(msf_pkg::FLAGS_OFS, b);
    rchk(msf_pkg::FLAGS_OFS, b, 32'h0);
  endtask : err_case

  // main sequence
  initial begin
    rst_b = 1'b0;
    reg_req = '0;
    axis_setting_bad = 6'h00;
    {axis_detail, test_detail, servo_detail} = '0;
    {test_req_fail, servo_prog_bad} = 2'b00;
    {mcr_start, mcr_done_ok} = 8'h00;
    cpu_reset_b = 4'hf;
    cpu_present = 4'hf;
    dly = 8'h00;
    cyc(8);
    rst_b <= 1'b1;
    cyc(4);
    // reset values and an unmapped place
    rchk(msf_pkg::FLAGS_OFS, '1, 32'h0);
    rchk(msf_pkg::CTRL_OFS, '1, 32'h0);
    wr(8'h30, 32'hffff_ffff);
    rchk(8'h30, '1, 32'h0);
    rchk(msf_pkg::PEER_CODE_OFS, '1, 32'h0);
    chk({31'h0, irq}, 32'h0);
    // axis flag follows the or of the settings, corners first
    for (int i = 0; i < 10; i++) begin
      @(posedge clk);
      axis_setting_bad <= (i == 0) ? 6'h00 : (i == 1) ? 6'h3f : 6'($random(seed));
      cyc(2);
      rchk(msf_pkg::FLAGS_OFS, fb(0), 32'(|axis_setting_bad));
    end
    axis_setting_bad <= 6'h00;
    cyc(2);
    d = {16'($random(seed)), 16'($random(seed)), 16'($random(seed))};
    axis_detail <= d;
    axis_setting_bad <= 6'h20;
    @(posedge clk);
    axis_detail <= ~d;
    cyc(2);
    for (int i = 0; i < 3; i++)
      rchk(msf_pkg::AXIS_DET0_OFS + 8'(4 * i), '1, {16'h0, d[47 - 16 * i -: 16]});
    @(posedge clk);
    axis_setting_bad <= 6'h00;
    // interrupt raised, masked, cleared
    wr(msf_pkg::IRQ_STAT_OFS, 32'h3f);
    wr(msf_pkg::IRQ_MASK_OFS, 32'h0);
    err_case(0);
    chk({31'h0, irq}, 32'h0);
    rchk(msf_pkg::IRQ_STAT_OFS, fb(msf_pkg::EV_TEST), fb(msf_pkg::EV_TEST));
    wr(msf_pkg::IRQ_MASK_OFS, fb(msf_pkg::EV_TEST));
    cyc(1);
    chk({31'h0, irq}, 32'h1);
    wr(msf_pkg::IRQ_STAT_OFS, fb(msf_pkg::EV_TEST));
    cyc(1);
    chk({31'h0, irq}, 32'h0);
    err_case(1);
    // parameter read, slow then prompt; a rise while busy is ignored
    for (int n = 0; n < 2; n++) begin
      ax = 8'($random(seed));
      dly <= n ? 8'h00 : 8'h14;
      wr(msf_pkg::CTRL_OFS, 32'h0);
      wr(msf_pkg::CTRL_OFS, {16'h0, ax, 8'h01});
      wait_sig(0);
      chk({24'h0, param_read_axis}, {24'h0, ax});
      if (n == 0) begin
        rchk(msf_pkg::FLAGS_OFS, fb(msf_pkg::READING_BIT), fb(msf_pkg::READING_BIT));
        rchk(msf_pkg::CTRL_OFS, 32'hff01, {16'h0, ax, 8'h01});
        wr(msf_pkg::CTRL_OFS, 32'h0);
        wr(msf_pkg::CTRL_OFS, {16'h0, ~ax, 8'h01});
      end
      wait_sig(1);
      cyc(10);
      rchk(msf_pkg::FLAGS_OFS, fb(msf_pkg::READING_BIT), 32'h0);
      chk({24'h0, axis_seen}, {24'h0, ax});
    end
    rchk(msf_pkg::IRQ_STAT_OFS, fb(msf_pkg::EV_PDONE), fb(msf_pkg::EV_PDONE));
    // read complete per cpu, cleared by a new command
    e = 32'h0;
    for (int c = 0; c < 4; c++) begin
      @(posedge clk);
      mcr_start <= 4'(1 << c);
      @(posedge clk);
      {mcr_start, mcr_done_ok} <= {4'h0, 4'(1 << c)};
      @(posedge clk);
      mcr_done_ok <= 4'h0;
      e = e | fb(msf_pkg::RD_DONE_LSB + c);
      rchk(msf_pkg::FLAGS_OFS, 32'hf00, e);
    end
    rchk(msf_pkg::IRQ_STAT_OFS, fb(msf_pkg::EV_MCR), fb(msf_pkg::EV_MCR));
    @(posedge clk);
    mcr_start <= 4'hf;
    @(posedge clk);
    mcr_start <= 4'h0;
    rchk(msf_pkg::FLAGS_OFS, 32'hf00, 32'h0);
    // reset of cpu2..4 raises the peer down error
    for (int c = 1; c < 4; c++) begin
      @(posedge clk);
      cpu_reset_b <= ~4'(1 << c);
      cyc(5);
      rchk(msf_pkg::FLAGS_OFS, 32'hf020, fb(12 + c) | fb(msf_pkg::PEER_DOWN_BIT));
      chk({15'h0, peer_down_err, peer_down_code}, {15'h0, 1'b1, 16'h1b58});
      @(posedge clk);
      cpu_reset_b <= 4'hf;
      cyc(5);
      wr(msf_pkg::FLAGS_OFS, fb(msf_pkg::PEER_DOWN_BIT));
      rchk(msf_pkg::FLAGS_OFS, 32'hf020, 32'h0);
    end
    // first cpu in reset spreads to all, without a peer down error
    @(posedge clk);
    cpu_reset_b <= 4'he;
    cyc(5);
    rchk(msf_pkg::FLAGS_OFS, 32'hf020, 32'hf000);
    @(posedge clk);
    cpu_reset_b <= 4'hf;
    cpu_present <= 4'hb;
    cyc(5);
    rchk(msf_pkg::FLAGS_OFS, 32'hf000, 32'h4000);
    @(posedge clk);
    cpu_present <= 4'hf;
    cyc(5);
    rchk(msf_pkg::FLAGS_OFS, 32'hf000, 32'h0);
    end_sim();
  end
endmodule : tb_msf_flag_bank
